/* rtl/pin_drive_mode_control.sv */
// Port of eight pins: AXI4-Lite registers, sync, edge interrupts, pads
`timescale 1ns/100ps
`default_nettype none
module pin_drive_mode_control (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pads
  input  wire logic [7:0]  pad_in,
  output logic [7:0]       pad_out,
  output logic [7:0]       pad_oe,
  output logic [7:0]       pad_pullup,
  output logic [7:0]       pad_pulldown,
  // Routing fabric
  input  wire logic [7:0]  fabric_out,
  input  wire logic [7:0]  fabric_oe_dummy_unused_n,
  output logic [7:0]       fabric_in,
  // USB engine mode select
  input  wire logic        usb_mode_sel,
  // Port interrupt
  output logic             port_irq
);
  localparam int N = pin_ctrl_pkg::NPINS;

  pin_cfg_if cfg ();
  pad_drive_decode u_dec (.cfg(cfg));

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [N-1:0]   output_write_register_r;
  logic [N-1:0]   dm0_r, dm1_r, dm2_r;
  logic [N-1:0]   byp_out_r, byp_in_r;
  logic [N-1:0]   rise_en_r, fall_en_r;
  logic [N-1:0]   irq_stat_r, irq_mask_r;
  logic [1:0]     usb_drv_r, usb_pull_r, usb_data_r;

  // Programmable reset image
  logic [N*3-1:0] rst_dm_r;
  logic [N-1:0]   rst_out_r;

  // Sampling and edge detect
  logic [N-1:0]   sync1_r, sync2_r, prev_r;
  logic [N-1:0]   pin_level_readback;
  logic [N-1:0]   edge_evt;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic       aw_hold_r, w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic       wr_fire;
  logic       wr_hit;

  // Pending answer stalls both
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign wr_fire = aw_hold_r && w_hold_r;

  // Each half waits for the other
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // Answer stands until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pin_ctrl_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? pin_ctrl_pkg::RESP_OKAY : pin_ctrl_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Port-form bytes use lane 0 only; pin-form and reset-mode words also take upper lanes
  logic       wr_lo;
  logic [7:0] wb;
  logic [2:0] wpin;
  logic       wr_pin;
  assign wr_lo  = wr_fire && w_strb_r[0];
  assign wb     = w_data_r[7:0];
  assign wpin   = aw_addr_r[4:2];
  // Pin-form window
  assign wr_pin = wr_fire && aw_addr_r[7:5] == pin_ctrl_pkg::OFF_PIN_BASE[7:5]
                  && aw_addr_r[1:0] == 2'b00;

  // Mapped and aligned only
  function automatic logic hit(input logic [7:0] a);
    if (a[7:6] == pin_ctrl_pkg::OFF_PIN_BASE[7:6] && a[5] == 1'b0 && a[1:0] == 2'b00) begin
      return 1'b1;
    end else if (a <= pin_ctrl_pkg::OFF_APPLY && a[1:0] == 2'b00) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction
  assign wr_hit = hit(aw_addr_r);

  // Port-form byte or one pin bit
  function automatic logic [N-1:0] upd(input logic [N-1:0] cur, input logic [7:0] ad,
                                       input logic [N-1:0] v, input int fb);
    logic [N-1:0] r;
    r = cur;
    if (wr_lo && aw_addr_r == ad) begin
      r = v;
    end
    if (wr_pin && w_strb_r[fb/8]) begin
      r[wpin] = w_data_r[fb];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration; both port and pin forms hit one store
  // Apply loads the reset image
  logic apply_rst;
  assign apply_rst = wr_lo && aw_addr_r == pin_ctrl_pkg::OFF_APPLY && wb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {dm2_r, dm1_r, dm0_r}   <= pin_ctrl_pkg::DM_RST_VAL;
      output_write_register_r <= pin_ctrl_pkg::BYTE_RST_VAL;
    end else if (apply_rst) begin
      for (int i = 0; i < N; i++) begin
        {dm2_r[i], dm1_r[i], dm0_r[i]} <= rst_dm_r[i*3 +: 3];
      end
      output_write_register_r <= rst_out_r;
    end else begin
      output_write_register_r <= upd(output_write_register_r, pin_ctrl_pkg::OFF_OUT_DATA,
                                     wb, pin_ctrl_pkg::PF_OUT);
      dm0_r <= upd(dm0_r, pin_ctrl_pkg::OFF_DM0, wb, pin_ctrl_pkg::PF_DM);
      dm1_r <= upd(dm1_r, pin_ctrl_pkg::OFF_DM1, wb, pin_ctrl_pkg::PF_DM + 1);
      dm2_r <= upd(dm2_r, pin_ctrl_pkg::OFF_DM2, wb, pin_ctrl_pkg::PF_DM + 2);
    end
  end

  // Routing, enables, reset image
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byp_out_r <= pin_ctrl_pkg::BYTE_RST_VAL;
      byp_in_r  <= pin_ctrl_pkg::BYTE_RST_VAL;
      rise_en_r <= pin_ctrl_pkg::BYTE_RST_VAL;
      fall_en_r <= pin_ctrl_pkg::BYTE_RST_VAL;
      irq_mask_r <= pin_ctrl_pkg::BYTE_RST_VAL;
      rst_dm_r  <= pin_ctrl_pkg::DM_RST_VAL;
      rst_out_r <= pin_ctrl_pkg::BYTE_RST_VAL;
    end else begin
      byp_out_r <= upd(byp_out_r, pin_ctrl_pkg::OFF_BYP_OUT, wb, pin_ctrl_pkg::PF_BYPO);
      byp_in_r  <= upd(byp_in_r, pin_ctrl_pkg::OFF_BYP_IN, wb, pin_ctrl_pkg::PF_BYPI);
      rise_en_r <= upd(rise_en_r, pin_ctrl_pkg::OFF_IRQ_RISE, wb, pin_ctrl_pkg::PF_RISE);
      fall_en_r <= upd(fall_en_r, pin_ctrl_pkg::OFF_IRQ_FALL, wb, pin_ctrl_pkg::PF_FALL);
      if (wr_lo && aw_addr_r == pin_ctrl_pkg::OFF_IRQ_MASK) begin
        irq_mask_r <= wb;
      end
      if (wr_fire && aw_addr_r == pin_ctrl_pkg::OFF_RST_DM) begin
        rst_dm_r <= w_data_r[N*3-1:0];
      end
      if (wr_lo && aw_addr_r == pin_ctrl_pkg::OFF_RST_OUT) begin
        rst_out_r <= wb;
      end
    end
  end

  // USB pin bits change only through their own register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_drv_r  <= 2'h0;
      usb_pull_r <= 2'h0;
      usb_data_r <= 2'h0;
    end else if (wr_lo && aw_addr_r == pin_ctrl_pkg::OFF_USB_CTRL) begin
      usb_drv_r  <= wb[pin_ctrl_pkg::UC_DRV +: 2];
      usb_pull_r <= wb[pin_ctrl_pkg::UC_PULL +: 2];
      usb_data_r <= wb[pin_ctrl_pkg::UC_DATA +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input sampling and edge interrupts
  // Two flops against metastability
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      prev_r  <= 8'h00;
    end else begin
      sync1_r <= pad_in;
      sync2_r <= sync1_r;
      // Gated level: a dead buffer fakes no edge
      prev_r  <= pin_level_readback;
    end
  end

  // Analog mode kills the input buffer of pins 0-5, so their readback sees zero; USB pins keep it on
  assign pin_level_readback = sync2_r & cfg.pad_ie;
  assign fabric_in = pin_level_readback & byp_in_r;
  assign edge_evt = (pin_level_readback & ~prev_r & rise_en_r)
                  | (~pin_level_readback & prev_r & fall_en_r);

  // A same-cycle edge beats the clear
  logic [N-1:0] stat_clr;
  assign stat_clr = (wr_lo && aw_addr_r == pin_ctrl_pkg::OFF_IRQ_STAT) ? wb : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= 8'h00;
    end else begin
      irq_stat_r <= (irq_stat_r & ~stat_clr) | edge_evt;
    end
  end

  // Level output
  assign port_irq = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive
  always_comb begin
    for (int i = 0; i < N; i++) begin
      cfg.pin_drive_mode_bits[i*3 +: 3] = {dm2_r[i], dm1_r[i], dm0_r[i]};
    end
  end
  // USB pins use their own data
  assign cfg.drv_value = (byp_out_r & fabric_out) | (~byp_out_r
                         & {usb_data_r, output_write_register_r[N-3:0]});
  assign cfg.usb_pin_drive_enable  = {usb_drv_r, 6'h00};
  assign cfg.usb_pin_pullup_enable = {usb_pull_r, 6'h00};
  assign cfg.usb_mode              = usb_mode_sel;

  // Pads mirror the decoder
  assign pad_out      = cfg.pad_out;
  assign pad_oe       = cfg.pad_oe;
  assign pad_pullup   = cfg.pad_pu;
  assign pad_pulldown = cfg.pad_pd;

  ////////////////////////////////////////////////////////////////////////////
  // Read path; processor and DMA share it
  logic [31:0] rd_val;
  logic        rd_ok;
  logic [2:0]  rpin;
  assign rpin = s_axi_araddr[4:2];

  // Pin-form words, then port-form
  always_comb begin
    rd_val = 32'h00000000;
    rd_ok  = hit(s_axi_araddr);
    if (s_axi_araddr[7:6] == pin_ctrl_pkg::OFF_PIN_BASE[7:6]) begin
      rd_val[pin_ctrl_pkg::PF_OUT]  = output_write_register_r[rpin];
      rd_val[pin_ctrl_pkg::PF_LVL]  = pin_level_readback[rpin];
      rd_val[pin_ctrl_pkg::PF_DM +: 3] = {dm2_r[rpin], dm1_r[rpin], dm0_r[rpin]};
      rd_val[pin_ctrl_pkg::PF_BYPO] = byp_out_r[rpin];
      rd_val[pin_ctrl_pkg::PF_BYPI] = byp_in_r[rpin];
      rd_val[pin_ctrl_pkg::PF_RISE] = rise_en_r[rpin];
      rd_val[pin_ctrl_pkg::PF_FALL] = fall_en_r[rpin];
    end else if (s_axi_araddr == pin_ctrl_pkg::OFF_OUT_DATA) begin
      rd_val[7:0] = output_write_register_r;
    end else if (s_axi_araddr == pin_ctrl_pkg::OFF_PIN_LEVEL) begin
      rd_val[7:0] = pin_level_readback;
    end else if (s_axi_araddr == pin_ctrl_pkg::OFF_DM0) begin
      rd_val[7:0] = dm0_r;
    end else if (s_axi_araddr == pin_ctrl_pkg::OFF_DM1) begin
      rd_val[7:0] = dm1_r;
    end else if (s_axi_araddr == pin_ctrl_pkg::OFF_DM2) begin
      rd_val[7:0] = dm2_r;
    end else if (s_axi_araddr == pin_ctrl_pkg::OFF_BYP_OUT) begin
      rd_val[7:0] = byp_out_r;
    end else if (s_axi_araddr == pin_ctrl_pkg::OFF_BYP_IN) begin
      rd_val[7:0] = byp_in_r;
    end else if (s_axi_araddr == pin_ctrl_pkg::OFF_IRQ_RISE) begin
      rd_val[7:0] = rise_en_r;
    end else if (s_axi_araddr == pin_ctrl_pkg::OFF_IRQ_FALL) begin
      rd_val[7:0] = fall_en_r;
    end else if (s_axi_araddr == pin_ctrl_pkg::OFF_IRQ_STAT) begin
      rd_val[7:0] = irq_stat_r;
    end else if (s_axi_araddr == pin_ctrl_pkg::OFF_IRQ_MASK) begin
      rd_val[7:0] = irq_mask_r;
    end else if (s_axi_araddr == pin_ctrl_pkg::OFF_USB_CTRL) begin
      rd_val[7:0] = {usb_data_r, usb_mode_sel, 1'b0, usb_pull_r, usb_drv_r};
    end else if (s_axi_araddr == pin_ctrl_pkg::OFF_RST_DM) begin
      rd_val[N*3-1:0] = rst_dm_r;
    end else if (s_axi_araddr == pin_ctrl_pkg::OFF_RST_OUT) begin
      rd_val[7:0] = rst_out_r;
    end
  end

  // One read at a time
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= pin_ctrl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_ok ? rd_val : 32'h00000000;
      s_axi_rresp  <= rd_ok ? pin_ctrl_pkg::RESP_OKAY : pin_ctrl_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* rtl/pin_ctrl_pkg.sv */
// Constants and types for the pin drive-mode control block
package pin_ctrl_pkg;

  localparam int NPINS = 8;
  localparam int NUSB  = 2;
  localparam int DMW   = 3;
  localparam int AW    = 8;

  // Byte addresses of the port-form registers
  localparam logic [AW-1:0] OFF_OUT_DATA  = 8'h00;
  localparam logic [AW-1:0] OFF_PIN_LEVEL = 8'h04;
  localparam logic [AW-1:0] OFF_DM0       = 8'h08;
  localparam logic [AW-1:0] OFF_DM1       = 8'h0C;
  localparam logic [AW-1:0] OFF_DM2       = 8'h10;
  localparam logic [AW-1:0] OFF_BYP_OUT   = 8'h14;
  localparam logic [AW-1:0] OFF_BYP_IN    = 8'h18;
  localparam logic [AW-1:0] OFF_IRQ_RISE  = 8'h1C;
  localparam logic [AW-1:0] OFF_IRQ_FALL  = 8'h20;
  localparam logic [AW-1:0] OFF_IRQ_STAT  = 8'h24;
  localparam logic [AW-1:0] OFF_IRQ_MASK  = 8'h28;
  localparam logic [AW-1:0] OFF_USB_CTRL  = 8'h2C;
  localparam logic [AW-1:0] OFF_RST_DM    = 8'h30;
  localparam logic [AW-1:0] OFF_RST_OUT   = 8'h34;
  localparam logic [AW-1:0] OFF_APPLY     = 8'h38;
  // Pin-form registers: one word per pin from this base
  localparam logic [AW-1:0] OFF_PIN_BASE  = 8'h40;

  // Pin-form field positions
  localparam int PF_OUT  = 0;
  localparam int PF_LVL  = 1;
  localparam int PF_DM   = 2;
  localparam int PF_BYPO = 5;
  localparam int PF_BYPI = 6;
  localparam int PF_RISE = 7;
  localparam int PF_FALL = 8;

  // USB control field positions (pin 6 and pin 7 pairs)
  localparam int UC_DRV   = 0;
  localparam int UC_PULL  = 2;
  localparam int UC_USB   = 5;
  localparam int UC_DATA  = 6;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [NPINS*DMW-1:0] DM_RST_VAL   = 24'h000000;
  localparam logic [NPINS-1:0]     BYTE_RST_VAL = 8'h00;

  typedef enum logic [2:0] {
    DM_HIZ_ANALOG = 3'h0,
    DM_HIZ_DIGITAL = 3'h1,
    DM_RES_UP     = 3'h2,
    DM_RES_DOWN   = 3'h3,
    DM_OD_LOW     = 3'h4,
    DM_OD_HIGH    = 3'h5,
    DM_STRONG     = 3'h6,
    DM_RES_UPDOWN = 3'h7
  } drive_select_field_t;

endpackage

/* rtl/pin_cfg_if.sv */
// Per-pin configuration carried from the register file to the pad decoder
`timescale 1ns/100ps
`default_nettype none
interface pin_cfg_if;
  logic [pin_ctrl_pkg::NPINS*pin_ctrl_pkg::DMW-1:0] pin_drive_mode_bits;
  logic [pin_ctrl_pkg::NPINS-1:0]                   drv_value;
  logic [pin_ctrl_pkg::NPINS-1:0]                   usb_pin_drive_enable;
  logic [pin_ctrl_pkg::NPINS-1:0]                   usb_pin_pullup_enable;
  logic                                             usb_mode;
  logic [pin_ctrl_pkg::NPINS-1:0]                   pad_oe;
  logic [pin_ctrl_pkg::NPINS-1:0]                   pad_out;
  logic [pin_ctrl_pkg::NPINS-1:0]                   pad_pu;
  logic [pin_ctrl_pkg::NPINS-1:0]                   pad_pd;
  logic [pin_ctrl_pkg::NPINS-1:0]                   pad_ie;
  modport regs (output pin_drive_mode_bits, drv_value, usb_pin_drive_enable,
                output usb_pin_pullup_enable, usb_mode,
                input  pad_oe, pad_out, pad_pu, pad_pd, pad_ie);
  modport dec  (input  pin_drive_mode_bits, drv_value, usb_pin_drive_enable,
                input  usb_pin_pullup_enable, usb_mode,
                output pad_oe, pad_out, pad_pu, pad_pd, pad_ie);
endinterface
`default_nettype wire

/* rtl/pad_drive_decode.sv */
// Drive-mode decoder: turns mode and data into pad controls
`timescale 1ns/100ps
`default_nettype none
module pad_drive_decode (
  pin_cfg_if.dec cfg
);
  genvar g;
  generate
    for (g = 0; g < pin_ctrl_pkg::NPINS; g++) begin : g_pin
      pin_ctrl_pkg::drive_select_field_t dsel;
      logic d;
      assign dsel = pin_ctrl_pkg::drive_select_field_t'(
                      cfg.pin_drive_mode_bits[g*pin_ctrl_pkg::DMW +: pin_ctrl_pkg::DMW]);
      assign d = cfg.drv_value[g];
      if (g >= pin_ctrl_pkg::NPINS - pin_ctrl_pkg::NUSB) begin : g_usb
        // USB engine owns the pad in USB mode
        always_comb begin
          cfg.pad_oe[g]  = 1'b0;
          cfg.pad_out[g] = 1'b0;
          cfg.pad_pu[g]  = 1'b0;
          cfg.pad_pd[g]  = 1'b0;
          cfg.pad_ie[g]  = 1'b1;
          if (!cfg.usb_mode) begin
            if (!d) begin
              cfg.pad_oe[g] = 1'b1;
            end else if (cfg.usb_pin_drive_enable[g]) begin
              cfg.pad_oe[g]  = 1'b1;
              cfg.pad_out[g] = 1'b1;
            end else begin
              cfg.pad_pu[g] = cfg.usb_pin_pullup_enable[g];
            end
          end
        end
      end else begin : g_gen
        always_comb begin
          cfg.pad_oe[g]  = 1'b0;
          cfg.pad_out[g] = d;
          cfg.pad_pu[g]  = 1'b0;
          cfg.pad_pd[g]  = 1'b0;
          cfg.pad_ie[g]  = (dsel != pin_ctrl_pkg::DM_HIZ_ANALOG);
          case (dsel)
            pin_ctrl_pkg::DM_RES_UP: begin
              cfg.pad_oe[g] = ~d;
              cfg.pad_pu[g] = d;
            end
            pin_ctrl_pkg::DM_RES_DOWN: begin
              cfg.pad_oe[g] = d;
              cfg.pad_pd[g] = ~d;
            end
            pin_ctrl_pkg::DM_OD_LOW:   cfg.pad_oe[g] = ~d;
            pin_ctrl_pkg::DM_OD_HIGH:  cfg.pad_oe[g] = d;
            pin_ctrl_pkg::DM_STRONG:   cfg.pad_oe[g] = 1'b1;
            pin_ctrl_pkg::DM_RES_UPDOWN: begin
              cfg.pad_pu[g] = d;
              cfg.pad_pd[g] = ~d;
            end
            default: cfg.pad_oe[g] = 1'b0;
          endcase
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* bench/pin_ctrl_properties.sv */
// Port-level assertions for the pin drive-mode control block
`timescale 1ns/100ps
`default_nettype none
module pin_ctrl_properties (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Bus handshakes
  input  wire logic       s_axi_awvalid,
  input  wire logic       s_axi_awready,
  input  wire logic       s_axi_wvalid,
  input  wire logic       s_axi_wready,
  input  wire logic       s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic       s_axi_arvalid,
  input  wire logic       s_axi_arready,
  input  wire logic       s_axi_rvalid,
  input  wire logic       s_axi_rready,
  // Pads and interrupt
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup,
  input  wire logic [7:0] pad_pulldown,
  input  wire logic       usb_mode_sel,
  input  wire logic       port_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered in time");
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered in time");
  a_write_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  a_read_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not retired");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_drive_excl: assert property ((pad_oe & (pad_pullup | pad_pulldown)) == 8'h00)
    else $error("strong drive and resistor together");
  a_pull_excl: assert property ((pad_pullup & pad_pulldown) == 8'h00)
    else $error("pull-up and pull-down together");
  a_usb_released: assert property (usb_mode_sel |-> pad_oe[7:6] == 2'h0 && pad_pullup[7:6] == 2'h0)
    else $error("usb pins driven in usb mode");
  a_irq_reset: assert property (disable iff (1'b0) !aresetn |=> !port_irq)
    else $error("interrupt high after reset");
endmodule
bind pin_drive_mode_control pin_ctrl_properties u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pad_oe(pad_oe), .pad_pullup(pad_pullup), .pad_pulldown(pad_pulldown),
  .usb_mode_sel(usb_mode_sel), .port_irq(port_irq));
`default_nettype wire

/* bench/pin_load_model.sv */
// External circuitry at the pins: optional driver, resistors, floating level
`timescale 1ns/100ps
`default_nettype none
module pin_load_model (
  // Clock
  input  wire logic       aclk,
  // Device pads
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup,
  input  wire logic [7:0] pad_pulldown,
  // External driver
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // Resolved pin level
  output logic [7:0]      pin_level
);
  logic [7:0] float_r = 8'h55;
  // Undriven pins toggle so a stale level can never pass for a real one
  always_ff @(posedge aclk) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ext_en[i])
        pin_level[i] = ext_val[i];
      else if (pad_oe[i])
        pin_level[i] = pad_out[i];
      else if (pad_pullup[i] || pad_pulldown[i])
        pin_level[i] = pad_pullup[i];
      else
        pin_level[i] = float_r[i];
    end
  end
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench: register tasks, drive modes, readback, interrupts, USB pins
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, usb_sel = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, fab_out = 8'h00, ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00, pin_lvl, p_out, p_oe, p_pu, p_pd, fab_in;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, irq;
  int n_errors = 0, total_checks = 0, cycles = 0;
  localparam logic [1:0] OK = pin_ctrl_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = pin_ctrl_pkg::RESP_SLVERR;
  pin_drive_mode_control DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pad_in(pin_lvl), .pad_out(p_out), .pad_oe(p_oe), .pad_pullup(p_pu),
    .pad_pulldown(p_pd), .fabric_out(fab_out), .fabric_oe_dummy_unused_n(8'h00),
    .fabric_in(fab_in), .usb_mode_sel(usb_sel), .port_irq(irq));
  pin_load_model u_load (.aclk(aclk), .pad_out(p_out), .pad_oe(p_oe), .pad_pullup(p_pu),
    .pad_pulldown(p_pd), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_lvl));
  always #5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_d = 1'b0, w_d = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(negedge aclk);
      aw_d |= awvalid & awready;
      w_d |= wvalid & wready;
      @(posedge aclk);
      if (aw_d) awvalid <= 1'b0;
      if (w_d) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    chk($sformatf("rdata at %h", a), e & m, rdata & m);
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // Sets all plane registers to one drive code
  task automatic set_mode(input logic [2:0] c);
    wr(pin_ctrl_pkg::OFF_DM0, c[0] ? 32'hFF : 32'h0, OK);
    wr(pin_ctrl_pkg::OFF_DM1, c[1] ? 32'hFF : 32'h0, OK);
    wr(pin_ctrl_pkg::OFF_DM2, c[2] ? 32'hFF : 32'h0, OK);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic oe, pu, pd;
    logic [7:0] u;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(pin_ctrl_pkg::OFF_DM0, 32'h0, 32'hFF, OK);
    for (int c = 0; c < 8; c++) begin
      set_mode(c[2:0]);
      for (int d = 0; d < 2; d++) begin
        wr(pin_ctrl_pkg::OFF_OUT_DATA, d ? 32'hFF : 32'h0, OK);
        @(negedge aclk);
        oe = (c == 6) || (c == 5 && d) || (c == 4 && !d) || (c == 3 && d) || (c == 2 && !d);
        pu = (c == 2 || c == 7) && d;
        pd = (c == 3 || c == 7) && !d;
        chk("pads", {8'h0, {6{oe}}, {6{oe && d}}, {6{pu}}, {6{pd}}},
            {8'h0, p_oe[5:0], p_out[5:0] & p_oe[5:0], p_pu[5:0], p_pd[5:0]});
      end
    end
    set_mode(3'h0);
    ext_en <= 8'h3F;
    ext_val <= 8'h25;
    rd(pin_ctrl_pkg::OFF_PIN_LEVEL, 32'h0, 32'h3F, OK);
    set_mode(3'h1);
    rd(pin_ctrl_pkg::OFF_PIN_LEVEL, 32'h25, 32'h3F, OK);
    chk("fabric_in off", 32'h0, {26'h0, fab_in[5:0]});
    wr(pin_ctrl_pkg::OFF_BYP_IN, 32'hFF, OK);
    chk("fabric_in on", 32'h25, {26'h0, fab_in[5:0]});
    ext_en <= 8'h00;
    set_mode(3'h6);
    fab_out <= 8'h2A;
    wr(pin_ctrl_pkg::OFF_OUT_DATA, 32'h0F, OK);
    wr(pin_ctrl_pkg::OFF_BYP_OUT, 32'h3C, OK);
    chk("bypass out", 32'h2B, {26'h0, p_out[5:0]});
    rd(pin_ctrl_pkg::OFF_OUT_DATA, 32'h0F, 32'h3F, OK);
    wr(pin_ctrl_pkg::OFF_BYP_OUT, 32'h0, OK);
    set_mode(3'h1);
    ext_val <= 8'h00;
    ext_en <= 8'h3F;
    wr(pin_ctrl_pkg::OFF_IRQ_RISE, 32'h05, OK);
    wr(pin_ctrl_pkg::OFF_IRQ_FALL, 32'h06, OK);
    wr(pin_ctrl_pkg::OFF_IRQ_STAT, 32'hFF, OK);
    wr(pin_ctrl_pkg::OFF_IRQ_MASK, 32'h07, OK);
    ext_val <= 8'h07;
    repeat (3) @(posedge aclk);
    rd(pin_ctrl_pkg::OFF_IRQ_STAT, 32'h05, 32'h3F, OK);
    chk("irq", 32'h1, {31'h0, irq});
    ext_val <= 8'h00;
    repeat (3) @(posedge aclk);
    rd(pin_ctrl_pkg::OFF_IRQ_STAT, 32'h07, 32'h3F, OK);
    wr(pin_ctrl_pkg::OFF_IRQ_STAT, 32'h05, OK);
    rd(pin_ctrl_pkg::OFF_IRQ_STAT, 32'h02, 32'h3F, OK);
    wr(pin_ctrl_pkg::OFF_IRQ_MASK, 32'h05, OK);
    chk("irq masked", 32'h0, {31'h0, irq});
    ext_en <= 8'h00;
    wr(pin_ctrl_pkg::OFF_PIN_BASE + 8'h08, 32'h19, OK);
    rd(pin_ctrl_pkg::OFF_DM2, 32'h04, 32'h04, OK);
    rd(pin_ctrl_pkg::OFF_DM0, 32'h0, 32'h04, OK);
    rd(pin_ctrl_pkg::OFF_OUT_DATA, 32'h04, 32'h04, OK);
    wr(pin_ctrl_pkg::OFF_DM0, 32'h04, OK);
    rd(pin_ctrl_pkg::OFF_PIN_BASE + 8'h08, 32'h1D, 32'h1FD, OK);
    for (int e = 0; e < 4; e++) begin
      u = 8'h40 | (e[1] ? 8'h0C : 8'h0) | (e[0] ? 8'h03 : 8'h0);
      wr(pin_ctrl_pkg::OFF_USB_CTRL, {24'h0, u}, OK);
      chk("usb pads", {24'h0, 1'b1, e[0], 1'b0, e[0], 1'b0, !e[0] && e[1], 2'h0},
          {24'h0, p_oe[7:6], p_out[7:6] & p_oe[7:6], p_pu[7:6], p_pd[7:6]});
    end
    set_mode(3'h0);
    rd(pin_ctrl_pkg::OFF_USB_CTRL, 32'h4F, 32'hCF, OK);
    usb_sel <= 1'b1;
    rd(pin_ctrl_pkg::OFF_USB_CTRL, 32'h20, 32'h20, OK);
    usb_sel <= 1'b0;
    wr(pin_ctrl_pkg::OFF_RST_DM, 32'hDB6DB6, OK);
    wr(pin_ctrl_pkg::OFF_RST_OUT, 32'h15, OK);
    wr(pin_ctrl_pkg::OFF_APPLY, 32'h01, OK);
    chk("reset state", 32'h3F15, {18'h0, p_oe[5:0], 2'h0, p_out[5:0]});
    rd(8'h3C, 32'h0, 32'hFFFFFFFF, ERR);
    wr(8'h3C, 32'h1, ERR);
    wr(8'h02, 32'h1, ERR);
    summarize();
  end
endmodule
`default_nettype wire
